// ### verif/eri_mem_model.sv
// behavioural memory and peripheral space on the far side of the decoder bus
`timescale 1ns/1ps
`default_nettype none
module eri_mem_model (
    input wire logic clk_sys,
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata
);
    logic [15:0] mem [0:65535];
    logic rd_q = 1'b0;
    logic [15:0] addr_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    // one flat space: memory and peripherals answer the very same strobes
    always @(posedge clk_sys) begin
        rd_q <= bus_rd;
        addr_q <= bus_addr;
        if (rd_q) begin
            last_q <= mem[addr_q];
        end
        if (bus_wr) begin
            mem[bus_addr] <= bus_wdata;
        end
    end
    // data only in the cycle after the strobe; otherwise the inverse, so a late sample shows
    assign bus_rdata = rd_q ? mem[addr_q] : ~last_q;
endmodule : eri_mem_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench that runs small programs through the decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import eri_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] ext_cond = 16'h0000;
    logic [2:0] view_sel = 3'h0;
    logic [15:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic [15:0] view_data;
    logic [15:0] pc;
    logic bus_rd;
    logic bus_wr;
    logic [3:0] flags;
    logic [15:0] pa = 16'h0000;
    int num_errors = 0;
    int total_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    eri_decoder i_eri_decoder (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ext_cond(ext_cond),
        .view_sel(view_sel), .view_data(view_data), .flags(flags), .pc(pc)
    );
    eri_mem_model i_eri_mem_model (
        .clk_sys(clk_sys), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata)
    );

    function automatic logic [15:0] enc(input logic [2:0] op, input logic [2:0] md,
                                        input logic [2:0] rg);
        enc = {6'h00, 1'b1, op, md, rg};
    endfunction : enc

    task automatic put(input logic [15:0] w);
        i_eri_mem_model.mem[pa] = w;
        pa = pa + 16'h0001;
    endtask : put

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_reg(input logic [2:0] r, input logic [15:0] exp);
        @(posedge clk_sys);
        view_sel <= r;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("register", exp, view_data);
    endtask : chk_reg

    // programs are loaded while the core is held in reset
    task automatic start;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        pa = 16'h0000;
    endtask : start

    task automatic finish_prog;
        logic [15:0] stop;
        int n;
        stop = pa;
        put(16'h0220);
        put(16'h0001);
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        n = 0;
        @(posedge clk_sys);
        #1;
        while (pc !== stop && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        total_checks++;
        if (n >= 3000) begin
            num_errors++;
            $display("unexpected final pc: expected %h seen %h", stop, pc);
        end
        repeat (20) @(posedge clk_sys);
    endtask : finish_prog

    task automatic s_alu;
        logic [2:0] ops [5] = '{OP_ADD, OP_SUB, OP_COMPARE, OP_AND, OP_XOR};
        logic [15:0] a [5] = '{16'h7FFF, 16'h0001, 16'h0005, 16'hF0F0, 16'h8000};
        logic [15:0] b [5] = '{16'h0001, 16'h0001, 16'h0007, 16'h0F0F, 16'h0001};
        logic [15:0] r [5] = '{16'h8000, 16'h0000, 16'h0005, 16'h0000, 16'h8001};
        logic [3:0] f [5] = '{4'hA, 4'h5, 4'h8, 4'h4, 4'h8};
        for (int i = 0; i < 5; i++) begin
            start;
            put(16'hFC00 | enc(OP_LOAD, MODE_IMM, 3'h2));
            put(a[i]);
            put(enc(ops[i], MODE_IMM, 3'h2));
            put(b[i]);
            // branch on zero skips the marker load
            put(16'h0204);
            put(16'h0002);
            put(enc(OP_LOAD, MODE_IMM, 3'h3));
            put(16'h00AA);
            finish_prog;
            chk_reg(3'h2, r[i]);
            chk_reg(3'h3, f[i][2] ? 16'h0000 : 16'h00AA);
            chk("flags", {12'h000, f[i]}, {12'h000, flags});
        end
    endtask : s_alu

    task automatic s_modes;
        start;
        i_eri_mem_model.mem[16'h0100] = 16'h1111;
        i_eri_mem_model.mem[16'h0110] = 16'h2222;
        put(enc(OP_LOAD, MODE_IMM, 3'h1));
        put(16'h0100);
        put(enc(OP_LOAD, MODE_IMM, 3'h4));
        put(16'h0110);
        put(enc(OP_LOAD, MODE_IMM, 3'h6));
        put(16'h0120);
        put(enc(OP_LOAD, 3'h1, 3'h2));
        put(enc(OP_LOAD, MODE_PINC_A, 3'h3));
        put(enc(OP_STORE, MODE_STACK, 3'h2));
        put(enc(OP_LOAD, MODE_STACK, 3'h0));
        put(enc(OP_STORE, MODE_DIRECT, 3'h3));
        put(16'hF000);
        finish_prog;
        chk_reg(3'h1, 16'h0100);
        chk_reg(3'h2, 16'h1111);
        chk_reg(3'h3, 16'h2222);
        chk_reg(3'h4, 16'h0111);
        chk_reg(3'h6, 16'h0120);
        chk_reg(3'h0, 16'h1111);
        chk("memory", 16'h1111, i_eri_mem_model.mem[16'h0120]);
        chk("memory", 16'h2222, i_eri_mem_model.mem[16'hF000]);
    endtask : s_modes

    task automatic s_prefix;
        start;
        i_eri_mem_model.mem[16'h0100] = 16'h5577;
        i_eri_mem_model.mem[16'h0140] = 16'hFFCD;
        i_eri_mem_model.mem[16'h0141] = 16'h00AB;
        put(enc(OP_LOAD, MODE_IMM, 3'h1));
        put(16'h0100);
        put(enc(OP_LOAD, MODE_IMM, 3'h4));
        put(16'h0140);
        put({6'h00, PREFIX_WORD});
        put(enc(OP_LOAD, MODE_IMM, 3'h0));
        put(16'hFF34);
        put(16'hAB12);
        put({6'h00, PREFIX_WORD});
        put(enc(OP_LOAD, 3'h1, 3'h2));
        put({6'h00, PREFIX_WORD});
        put(enc(OP_LOAD, MODE_PINC_A, 3'h3));
        finish_prog;
        chk_reg(3'h0, 16'h1234);
        chk_reg(3'h2, 16'h7777);
        chk_reg(3'h3, 16'hABCD);
        chk_reg(3'h4, 16'h0142);
    endtask : s_prefix

    task automatic s_branch;
        start;
        ext_cond <= 16'h0008;
        put(enc(OP_LOAD, MODE_IMM, 3'h0));
        put(16'h0000);
        put(16'h0213);
        put(16'h0002);
        put(enc(OP_LOAD, MODE_IMM, 3'h0));
        put(16'hDEAD);
        put(16'h0212);
        put(16'h0000);
        put(enc(OP_LOAD, MODE_IMM, 3'h1));
        put(16'h0042);
        // counter already points past the immediate word when the add lands
        put(enc(OP_ADD, MODE_IMM, 3'h7));
        put(16'h0002);
        put(enc(OP_LOAD, MODE_IMM, 3'h1));
        put(16'hBAD0);
        put(16'h0200);
        put(16'h0004);
        put(enc(OP_LOAD, MODE_IMM, 3'h2));
        put(16'h0077);
        put(16'h0200);
        put(16'h0002);
        put(16'h0220);
        put(16'h0005);
        finish_prog;
        chk_reg(3'h0, 16'h0000);
        chk_reg(3'h1, 16'h0042);
        chk_reg(3'h2, 16'h0077);
    endtask : s_branch

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // whole run is well under ten thousand cycles; this bounds a lock-up
    initial begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        $display("unexpected timeout: expected done seen running");
        close_out;
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        s_alu;
        s_modes;
        s_prefix;
        s_branch;
        close_out;
    end
endmodule : testbench
`default_nettype wire

// ### verilog/eri_decoder.sv
// instruction decode and execute engine for external reference instructions
// Overview of operation
// - only bits 9..0 of a fetched word form the instruction
// - bits 9..6 are the operation field, two groups of eight
// - bit 9 set marks external reference: register to bus address traffic
// - eight 16-bit working registers, all data and ALU paths 16 bits
// - carry from add, subtract, compare; subtract adds two's complement
// - overflow set on two's complement overflow of add, subtract, compare
// - zero flag set when the result is all zeros
// - sign flag copies the result's top bit
// - one 16-bit address space for memory and peripherals alike
// - opcodes: store 001, load 010, add 011, sub 100, compare 101, and 110, xor 111
// - low three bits name the source or destination register
// - mode 0 takes the next word as address, program counter plus two
// - modes 1 to 3 address through that register, left unchanged
// - modes 4 and 5 address through the register, then increment it
// - mode 6 stack: push post-increments, pull pre-decrements register 6
// - mode 7 immediate: operand at program counter plus one
// - after the prefix two words give low byte then high byte
// - prefix: two words in modes 4,5,7; one doubled byte in modes 1-3
// - opcode 000 branches; bit 4 picks external inputs, four bits pick one
// - false: fall through; true: add displacement, complemented if backward
// - program counter advances first, so register 7 as target branches
// - second operand and result live in the named register
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module eri_decoder (
    input wire logic clk_sys,
    input wire logic sys_rst,
    output logic [eri_pkg::XLEN-1:0] bus_addr,
    output logic bus_rd,
    output logic bus_wr,
    output logic [eri_pkg::XLEN-1:0] bus_wdata,
    input wire logic [eri_pkg::XLEN-1:0] bus_rdata,
    input wire logic [eri_pkg::NCOND-1:0] ext_cond,
    input wire logic [2:0] view_sel,
    output logic [eri_pkg::XLEN-1:0] view_data,
    output logic [3:0] flags,
    output logic [eri_pkg::XLEN-1:0] pc
);
    import eri_pkg::*;

    eri_state_t state_q, state_d;
    eri_word_t regs_q [NREG];
    eri_word_t regs_d [NREG];
    logic [IW-1:0] ir_q, ir_d;
    eri_word_t eff_addr_q, eff_addr_d, opnd_q, opnd_d;
    logic [BYTE_W-1:0] lo_q, lo_d;
    logic dbl_q, dbl_d;
    logic [1:0] phase_q, phase_d;
    logic [3:0] flags_q, flags_d;
    eri_word_t addr_q, addr_d, wdata_q, wdata_d, view_q, view_d;
    logic rd_q, rd_d, wr_q, wr_d;
    logic [NCOND-1:0] ext_meta_q, ext_sync_q;

    // decode straight from the bus in the decode cycle, from ir_q afterwards
    logic [IW-1:0] iw;
    eri_op_t opc_w, opc;
    logic [2:0] mode_w, tgt_w, mode, tgt;
    eri_word_t pc_inc;

    assign iw = (state_q == ST_DECODE) ? bus_rdata[IW-1:0] : ir_q;
    assign opc_w = eri_op_t'(iw[OP_HI:OP_LO]);
    assign mode_w = iw[MODE_HI:MODE_LO];
    assign tgt_w = iw[TGT_HI:TGT_LO];
    assign opc = eri_op_t'(ir_q[OP_HI:OP_LO]);
    assign mode = ir_q[MODE_HI:MODE_LO];
    assign tgt = ir_q[TGT_HI:TGT_LO];
    assign pc_inc = regs_q[PC_IDX] + ONE;

    // ALU: subtract and compare add the inverted operand plus one
    eri_word_t a_op, b_op, res;
    logic [XLEN:0] sum;
    logic ovf, arith, logic_op;
    assign a_op = regs_q[tgt];
    assign b_op = (opc == OP_ADD) ? opnd_q : ~opnd_q;
    assign sum = {1'b0, a_op} + {1'b0, b_op} + {{XLEN{1'b0}}, opc != OP_ADD};
    assign ovf = (a_op[XLEN-1] == b_op[XLEN-1]) && (sum[XLEN-1] != a_op[XLEN-1]);
    assign arith = (opc == OP_ADD) || (opc == OP_SUB) || (opc == OP_COMPARE);
    assign logic_op = (opc == OP_AND) || (opc == OP_XOR);

    always_comb begin
        case (opc)
            OP_LOAD: res = opnd_q;
            OP_AND: res = a_op & opnd_q;
            OP_XOR: res = a_op ^ opnd_q;
            OP_ADD, OP_SUB, OP_COMPARE: res = sum[XLEN-1:0];
            default: res = a_op;
        endcase
    end

    // branch conditions: low three bits pick a flag test, bit 3 inverts it
    logic [COND_HI:0] ccode;
    logic cbase, cond_true;
    eri_word_t br_target;
    assign ccode = ir_q[COND_HI:0];

    always_comb begin
        case (ccode[2:0])
            3'h0: cbase = 1'b1;
            3'h1: cbase = flags_q[FL_C];
            3'h2: cbase = flags_q[FL_WRAP];
            3'h3: cbase = ~flags_q[FL_S];
            3'h4: cbase = flags_q[FL_Z];
            3'h5: cbase = flags_q[FL_S] ^ flags_q[FL_WRAP];
            3'h6: cbase = flags_q[FL_Z] | (flags_q[FL_S] ^ flags_q[FL_WRAP]);
            default: cbase = flags_q[FL_S] ^ flags_q[FL_C];
        endcase
    end

    // status pins arrive two flops late: a pin must settle before the branch executes
    assign cond_true = ir_q[COND_EXT_BIT] ? ext_sync_q[ccode] : (cbase ^ ccode[3]);
    assign br_target = regs_q[PC_IDX] + (ir_q[DIR_BIT] ? ~opnd_q : opnd_q);

    // modes 0 and 6 under the prefix fall back to a plain single word
    logic two_word, dup_byte;
    assign two_word = mode[2] && (mode != MODE_STACK);
    assign dup_byte = !mode[2] && (mode != MODE_DIRECT);

    always_comb begin
        state_d = state_q;
        regs_d = regs_q;
        ir_d = ir_q;
        eff_addr_d = eff_addr_q;
        opnd_d = opnd_q;
        lo_d = lo_q;
        dbl_d = dbl_q;
        phase_d = phase_q;
        flags_d = flags_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        view_d = regs_q[view_sel];
        case (state_q)
            ST_START: begin
                addr_d = regs_q[PC_IDX];
                rd_d = 1'b1;
                state_d = ST_FETCH;
            end
            ST_FETCH: begin
                state_d = ST_DECODE;
            end
            ST_DECODE: begin
                ir_d = iw;
                regs_d[PC_IDX] = pc_inc;
                if (!iw[EXT_BIT]) begin
                    // internal group is not executed here; only the prefix is kept
                    dbl_d = (iw == PREFIX_WORD);
                    addr_d = pc_inc;
                    rd_d = 1'b1;
                    state_d = ST_FETCH;
                end else begin
                    state_d = ST_ACC;
                    phase_d = PH_FIRST;
                    if (opc_w == OP_BRANCH || mode_w == MODE_DIRECT) begin
                        eff_addr_d = pc_inc;
                        regs_d[PC_IDX] = pc_inc + ONE;
                        phase_d = PH_ADDR;
                    end else if (mode_w == MODE_STACK && opc_w != OP_STORE) begin
                        eff_addr_d = regs_q[SP_IDX] - ONE;
                        regs_d[SP_IDX] = eff_addr_d;
                    end else begin
                        eff_addr_d = regs_d[mode_w];
                        if (mode_w[2]) begin
                            regs_d[mode_w] = eff_addr_d + ONE;
                        end
                    end
                    addr_d = eff_addr_d;
                    if (phase_d == PH_ADDR || opc_w != OP_STORE) begin
                        rd_d = 1'b1;
                    end else begin
                        wr_d = 1'b1;
                        wdata_d = regs_d[tgt_w];
                    end
                end
            end
            ST_ACC: begin
                // a store has no data cycle, so the next fetch follows it at once
                if (wr_q) begin
                    addr_d = regs_q[PC_IDX];
                    rd_d = 1'b1;
                    dbl_d = 1'b0;
                    state_d = ST_FETCH;
                end else begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                case (phase_q)
                    PH_ADDR: begin
                        if (opc == OP_BRANCH) begin
                            opnd_d = bus_rdata;
                            state_d = ST_EXEC;
                        end else begin
                            eff_addr_d = bus_rdata;
                            addr_d = bus_rdata;
                            rd_d = (opc != OP_STORE);
                            wr_d = (opc == OP_STORE);
                            wdata_d = regs_q[tgt];
                            phase_d = PH_FIRST;
                            state_d = ST_ACC;
                        end
                    end
                    PH_FIRST: begin
                        if (dbl_q && two_word) begin
                            lo_d = bus_rdata[BYTE_W-1:0];
                            eff_addr_d = eff_addr_q + ONE;
                            regs_d[mode] = regs_q[mode] + ONE;
                            addr_d = eff_addr_q + ONE;
                            rd_d = 1'b1;
                            phase_d = PH_SECOND;
                            state_d = ST_ACC;
                        end else begin
                            if (dbl_q && dup_byte) begin
                                opnd_d = {bus_rdata[BYTE_W-1:0], bus_rdata[BYTE_W-1:0]};
                            end else begin
                                opnd_d = bus_rdata;
                            end
                            state_d = ST_EXEC;
                        end
                    end
                    default: begin
                        opnd_d = {bus_rdata[BYTE_W-1:0], lo_q};
                        state_d = ST_EXEC;
                    end
                endcase
            end
            ST_EXEC: begin
                if (opc == OP_BRANCH) begin
                    if (cond_true) begin
                        regs_d[PC_IDX] = br_target;
                    end
                end else begin
                    if (opc != OP_COMPARE) begin
                        regs_d[tgt] = res;
                    end
                    if (arith) begin
                        flags_d[FL_C] = sum[XLEN];
                        flags_d[FL_WRAP] = ovf;
                    end
                    if (arith || logic_op) begin
                        flags_d[FL_Z] = (res == RESET_WORD);
                        flags_d[FL_S] = res[XLEN-1];
                    end
                end
                addr_d = regs_d[PC_IDX];
                rd_d = 1'b1;
                dbl_d = 1'b0;
                state_d = ST_FETCH;
            end
            default: begin
                state_d = ST_START;
            end
        endcase
    end

    // one flop group per register keeps every element a single-process driver
    for (genvar g = 0; g < NREG; g++) begin : g_regs
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                regs_q[g] <= RESET_WORD;
            end else begin
                regs_q[g] <= regs_d[g];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_START;
            ir_q <= '0;
            eff_addr_q <= RESET_WORD;
            opnd_q <= RESET_WORD;
            lo_q <= '0;
            dbl_q <= 1'b0;
            phase_q <= PH_ADDR;
            flags_q <= '0;
            addr_q <= RESET_WORD;
            wdata_q <= RESET_WORD;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            view_q <= RESET_WORD;
            ext_meta_q <= '0;
            ext_sync_q <= '0;
        end else begin
            state_q <= state_d;
            ir_q <= ir_d;
            eff_addr_q <= eff_addr_d;
            opnd_q <= opnd_d;
            lo_q <= lo_d;
            dbl_q <= dbl_d;
            phase_q <= phase_d;
            flags_q <= flags_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            view_q <= view_d;
            // status pins are asynchronous to clk_sys
            ext_meta_q <= ext_cond;
            ext_sync_q <= ext_meta_q;
        end
    end

    assign bus_addr = addr_q;
    assign bus_rd = rd_q;
    assign bus_wr = wr_q;
    assign bus_wdata = wdata_q;
    assign view_data = view_q;
    assign flags = flags_q;
    assign pc = regs_q[PC_IDX];

    // properties below check what this block drives, keyed on its own state and on the incoming bus_rdata
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_upper_bits_dropped: assert property (
        state_q == ST_DECODE |=> ir_q == $past(bus_rdata[IW-1:0]))
        else $error("instruction register differs from low bits of fetched word");
    a_pc_first_step: assert property (
        state_q == ST_DECODE && !bus_rdata[EXT_BIT] |=> pc == $past(pc) + ONE)
        else $error("program counter did not advance by one");
    a_post_inc_reg: assert property (
        state_q == ST_DECODE && bus_rdata[EXT_BIT] && bus_rdata[OP_HI:OP_LO] != OP_BRANCH
        && bus_rdata[MODE_HI:MODE_LO] == MODE_PINC_A
        |=> regs_q[MODE_PINC_A] == $past(regs_q[MODE_PINC_A]) + ONE
        && bus_addr == $past(regs_q[MODE_PINC_A]))
        else $error("post-increment register wrong");
    a_stack_pull: assert property (
        state_q == ST_DECODE && bus_rdata[EXT_BIT] && bus_rdata[OP_HI:OP_LO] != OP_STORE
        && bus_rdata[OP_HI:OP_LO] != OP_BRANCH && bus_rdata[MODE_HI:MODE_LO] == MODE_STACK
        |=> regs_q[SP_IDX] == $past(regs_q[SP_IDX]) - ONE && bus_addr == regs_q[SP_IDX])
        else $error("stack pull did not pre-decrement");
    a_direct_address: assert property (
        state_q == ST_DATA && phase_q == PH_ADDR && opc != OP_BRANCH
        |=> bus_addr == $past(bus_rdata) && (bus_rd || bus_wr))
        else $error("direct address not taken from the second word");
    a_carry_flag: assert property (
        state_q == ST_EXEC && arith |=> flags_q[FL_C] == $past(sum[XLEN]))
        else $error("carry flag wrong");
    a_ovf_flag: assert property (
        state_q == ST_EXEC && opc == OP_ADD && a_op[XLEN-1] == opnd_q[XLEN-1]
        |=> flags_q[FL_WRAP] == (regs_q[$past(tgt)][XLEN-1] != $past(a_op[XLEN-1])))
        else $error("overflow flag wrong");
    a_zero_sign: assert property (
        state_q == ST_EXEC && logic_op
        |=> flags_q[FL_Z] == (regs_q[$past(tgt)] == RESET_WORD)
        && flags_q[FL_S] == regs_q[$past(tgt)][XLEN-1])
        else $error("zero or sign flag wrong");
    a_branch_false: assert property (
        state_q == ST_EXEC && opc == OP_BRANCH && !cond_true
        |=> pc == $past(pc) && bus_rd && bus_addr == pc)
        else $error("untaken branch moved the program counter");

    a_store_data: assert property (
        state_q == ST_DECODE && bus_rdata[EXT_BIT] && bus_rdata[OP_HI:OP_LO] == OP_STORE
        && bus_rdata[MODE_HI:MODE_LO] != MODE_DIRECT && bus_rdata[TGT_HI:TGT_LO] != PC_IDX
        && bus_rdata[TGT_HI:TGT_LO] != bus_rdata[MODE_HI:MODE_LO]
        |=> bus_wr && !bus_rd && bus_wdata == $past(regs_q[bus_rdata[TGT_HI:TGT_LO]]))
        else $error("store strobe or data wrong");

    a_second_byte_read: assert property (
        state_q == ST_DATA && phase_q == PH_FIRST && dbl_q && two_word
        |=> bus_rd && bus_addr == $past(eff_addr_q) + ONE && phase_q == PH_SECOND)
        else $error("second byte not read from the next address");

    a_single_strobe: assert property (
        !(bus_rd && bus_wr))
        else $error("read and write strobes high together");

    a_direct_pc_step: assert property (
        state_q == ST_DECODE && bus_rdata[EXT_BIT] && bus_rdata[MODE_HI:MODE_LO] == MODE_DIRECT
        |=> pc == $past(pc) + ONE + ONE && bus_rd && bus_addr == $past(pc) + ONE)
        else $error("direct mode did not step the counter by two");

    // main scenarios; the bench reaches all but c_pc_target, as it only adds to register 7 and never loads it
    c_store_seen: cover property (state_q == ST_ACC && bus_wr);
    c_double_byte: cover property (state_q == ST_DATA && phase_q == PH_SECOND);
    c_branch_taken: cover property (state_q == ST_EXEC && opc == OP_BRANCH && cond_true);
    c_pc_target: cover property (state_q == ST_EXEC && opc == OP_LOAD && tgt == PC_IDX);
    c_ext_branch: cover property (state_q == ST_EXEC && opc == OP_BRANCH && ir_q[COND_EXT_BIT]);
endmodule : eri_decoder
`default_nettype wire

// ### verilog/eri_pkg.sv
// shared constants and types for the external reference decoder
package eri_pkg;
    localparam int XLEN = 16;
    localparam int IW = 10;
    localparam int NREG = 8;
    localparam int NCOND = 16;
    typedef logic [XLEN-1:0] eri_word_t;
    // instruction field positions inside the 10-bit word
    localparam int EXT_BIT = 9;
    localparam int OP_HI = 8;
    localparam int OP_LO = 6;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 3;
    localparam int TGT_HI = 2;
    localparam int TGT_LO = 0;
    localparam int DIR_BIT = 5;
    localparam int COND_EXT_BIT = 4;
    localparam int COND_HI = 3;
    localparam int BYTE_W = 8;
    localparam logic [IW-1:0] PREFIX_WORD = 10'h001;
    typedef enum logic [2:0] {
        OP_BRANCH = 3'b000,
        OP_STORE = 3'b001,
        OP_LOAD = 3'b010,
        OP_ADD = 3'b011,
        OP_SUB = 3'b100,
        OP_COMPARE = 3'b101,
        OP_AND = 3'b110,
        OP_XOR = 3'b111
    } eri_op_t;
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_PINC_A = 3'h4;
    localparam logic [2:0] MODE_PINC_B = 3'h5;
    localparam logic [2:0] MODE_STACK = 3'h6;
    localparam logic [2:0] MODE_IMM = 3'h7;
    localparam logic [2:0] PC_IDX = 3'h7;
    localparam logic [2:0] SP_IDX = 3'h6;
    localparam eri_word_t ONE = 16'h0001;
    localparam eri_word_t RESET_WORD = 16'h0000;
    localparam int FL_C = 0;
    localparam int FL_WRAP = 1;
    localparam int FL_Z = 2;
    localparam int FL_S = 3;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_FIRST = 2'h1;
    localparam logic [1:0] PH_SECOND = 2'h2;
    typedef enum logic [2:0] {
        ST_START = 3'b000,
        ST_FETCH = 3'b001,
        ST_DECODE = 3'b010,
        ST_ACC = 3'b011,
        ST_DATA = 3'b100,
        ST_EXEC = 3'b101
    } eri_state_t;
endpackage : eri_pkg
